// *** rtl/boost_reg_two_pkg.sv ***
// Purpose: Constants and types for the boost regulation and mode control register.
// Assumes: Frames arrive already decoded by the serial front end.
// Notes:   All offsets and positions live here, and every reset value except those of the role and shutoff bits.
package boost_reg_two_pkg;

  // ----------------------------------------------------------------
  // Addresses and field positions
  // ----------------------------------------------------------------
  localparam logic [5:0] GUARD_REG_ADDR = 6'h01;  // Register holding the guard release bit
  localparam logic [5:0] MODE_REG_ADDR  = 6'h02;  // This register
  localparam int GUARD_BIT_POS  = 1;
  localparam int SLOPE_MSB      = 23;
  localparam int SLOPE_LSB      = 18;
  localparam int SHUTOFF_POS    = 17;
  localparam int GM_MSB         = 15;
  localparam int GM_LSB         = 14;
  localparam int LIMIT_MSB      = 13;
  localparam int LIMIT_LSB      = 12;
  localparam int VOUT_MSB       = 11;
  localparam int VOUT_LSB       = 5;
  localparam int SLEEP_POS      = 3;
  localparam int RUN_POS        = 2;
  localparam int ROLE_POS       = 1;

  // ----------------------------------------------------------------
  // Reset values (before OTP defaults are loaded)
  // ----------------------------------------------------------------
  localparam logic [5:0] SLOPE_RST   = 6'h00;
  localparam logic [1:0] GM_RST      = 2'h0;
  localparam logic [1:0] LIMIT_RST   = 2'h0;
  localparam logic [6:0] VOUT_RST    = 7'h00;
  localparam logic       SLEEP_RST   = 1'b0;
  localparam logic       RUN_RST     = 1'b0;

  // ----------------------------------------------------------------
  // Analog decode constants
  // ----------------------------------------------------------------
  localparam logic [9:0]  GM_BASE_US   = 10'h0c8;  // 200 uS
  localparam logic [9:0]  GM_STEP_US   = 10'h0c8;  // 200 uS per code
  localparam logic [7:0]  LIMIT_MV_0   = 8'h32;    // 50 mV
  localparam logic [7:0]  LIMIT_MV_1   = 8'h55;    // 85 mV
  localparam logic [7:0]  LIMIT_MV_2   = 8'h73;    // 115 mV
  localparam logic [7:0]  LIMIT_MV_3   = 8'h96;    // 150 mV
  localparam logic [12:0] VOUT_BASE_10MV = 13'h05be; // 14.7 V
  localparam logic [12:0] VOUT_STEP_10MV = 13'h0033; // 0.51 V

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        write;
    logic [5:0]  addr;
    logic [23:0] data;
  } frame_t;

  typedef struct packed {
    logic [5:0] slope;
    logic       shutoff;
    logic [1:0] gm;
    logic [1:0] limit;
    logic [6:0] vout;
    logic       role;
  } otp_defaults_t;

  typedef enum logic [1:0] {
    MODE_LIMP    = 2'b00,
    MODE_ACTIVE  = 2'b01,
    MODE_STANDBY = 2'b10
  } op_mode_t;

endpackage : boost_reg_two_pkg

// *** rtl/boost_regulation_and_mode_control.sv ***
// Purpose: Regulation and mode control register with write guard and parity check.
// Assumes: One decoded frame per frame_valid_i pulse, synchronous to clk_i.
// Notes:   OTP defaults load on the first edge after reset release.
`timescale 1ns/100ps
`default_nettype none

module boost_regulation_and_mode_control (
  // Clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  // Decoded serial frames
  input  wire logic                             frame_valid_i,
  input  wire boost_reg_two_pkg::frame_t        frame_i,
  input  wire logic                             wake_i,
  // One-time-programmable defaults
  input  wire boost_reg_two_pkg::otp_defaults_t otp_i,
  // Read back
  output logic                                  rd_valid_o,
  output logic [23:0]                           rd_data_o,
  output logic                                  parity_err_o,
  output logic                                  guard_open_o,
  // Control fields and decoded values
  output logic [5:0]                            slope_comp_setting_o,
  output logic                                  amp_shutoff_bit_o,
  output logic [9:0]                            amp_transconductance_us_o,
  output logic [7:0]                            shunt_current_limit_mv_o,
  output logic [6:0]                            output_voltage_code_o,
  output logic [12:0]                           vout_10mv_o,
  output boost_reg_two_pkg::op_mode_t           op_mode_o,
  // Sync pin and boost clock
  input  wire logic                             boost_clk_i,
  input  wire logic                             sync_pin_i,
  output logic                                  sync_pin_o,
  output logic                                  sync_pin_oe_o,
  output logic                                  boost_clk_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Guarded bit: a one lands only while the guard is open
  function automatic logic guarded(input logic wr, input logic old, input logic open);
    guarded = open ? wr : (wr & old);
  endfunction : guarded

  function automatic boost_reg_two_pkg::op_mode_t mode_of(input logic sleep, input logic run);
    case ({sleep, run})
      2'b10:   mode_of = boost_reg_two_pkg::MODE_STANDBY;
      2'b01:   mode_of = boost_reg_two_pkg::MODE_ACTIVE;
      2'b11:   mode_of = boost_reg_two_pkg::MODE_ACTIVE;
      default: mode_of = boost_reg_two_pkg::MODE_LIMP;
    endcase
  endfunction : mode_of

  logic       otp_pending_reg;
  logic       role_reg;
  logic       sleep_reg;
  logic       run_reg;
  logic [1:0] gm_reg;
  logic [1:0] limit_reg;
  logic       parity_ok;
  logic       good_frame;
  logic       wr_mode;
  logic       unlock_frame;
  logic [23:0] rd_image;

  // Odd parity over all 24 bits, parity bit included
  assign parity_ok    = ^frame_i.data;
  assign good_frame   = frame_valid_i & parity_ok & ~otp_pending_reg;
  assign wr_mode      = good_frame & frame_i.write & (frame_i.addr == boost_reg_two_pkg::MODE_REG_ADDR);
  assign unlock_frame = good_frame & frame_i.write
                      & (frame_i.addr == boost_reg_two_pkg::GUARD_REG_ADDR)
                      & frame_i.data[boost_reg_two_pkg::GUARD_BIT_POS];

  // Read image, unused bits forced low and parity made odd
  always_comb begin
    rd_image = {slope_comp_setting_o, amp_shutoff_bit_o, 1'b0, gm_reg, limit_reg,
                output_voltage_code_o, 1'b0, sleep_reg, run_reg, role_reg, 1'b0};
    rd_image[0] = ~^rd_image[23:1];
  end

  // ----------------------------------------------------------------
  // OTP default load
  // ----------------------------------------------------------------
  // Pending flag so defaults are sampled by a clocked process
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otp_pending_reg <= 1'b1;
    end else begin
      otp_pending_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write guard
  // ----------------------------------------------------------------
  // Opens on an unlock write, closes on any other good frame
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      guard_open_o <= 1'b0;
    end else if (good_frame) begin
      guard_open_o <= unlock_frame;
    end
  end

  // ----------------------------------------------------------------
  // Unguarded fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slope_comp_setting_o  <= boost_reg_two_pkg::SLOPE_RST;
      gm_reg                <= boost_reg_two_pkg::GM_RST;
      limit_reg             <= boost_reg_two_pkg::LIMIT_RST;
      output_voltage_code_o <= boost_reg_two_pkg::VOUT_RST;
      role_reg              <= 1'b0;
    end else if (otp_pending_reg) begin
      slope_comp_setting_o  <= otp_i.slope;
      gm_reg                <= otp_i.gm;
      limit_reg             <= otp_i.limit;
      output_voltage_code_o <= otp_i.vout;
      role_reg              <= otp_i.role;
    end else if (wr_mode) begin
      slope_comp_setting_o  <= frame_i.data[boost_reg_two_pkg::SLOPE_MSB:boost_reg_two_pkg::SLOPE_LSB];
      gm_reg                <= frame_i.data[boost_reg_two_pkg::GM_MSB:boost_reg_two_pkg::GM_LSB];
      limit_reg             <= frame_i.data[boost_reg_two_pkg::LIMIT_MSB:boost_reg_two_pkg::LIMIT_LSB];
      output_voltage_code_o <= frame_i.data[boost_reg_two_pkg::VOUT_MSB:boost_reg_two_pkg::VOUT_LSB];
      role_reg              <= frame_i.data[boost_reg_two_pkg::ROLE_POS];
    end
  end

  // ----------------------------------------------------------------
  // Guarded bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      amp_shutoff_bit_o <= 1'b0;
      sleep_reg         <= boost_reg_two_pkg::SLEEP_RST;
      run_reg           <= boost_reg_two_pkg::RUN_RST;
    end else if (otp_pending_reg) begin
      amp_shutoff_bit_o <= otp_i.shutoff;
    end else begin
      if (wr_mode) begin
        amp_shutoff_bit_o <= guarded(frame_i.data[boost_reg_two_pkg::SHUTOFF_POS],
                                     amp_shutoff_bit_o, guard_open_o);
        sleep_reg <= guarded(frame_i.data[boost_reg_two_pkg::SLEEP_POS],
                             sleep_reg, guard_open_o);
      end
      if (wake_i) begin
        run_reg <= 1'b0;
      end else if (wr_mode) begin
        run_reg <= guarded(frame_i.data[boost_reg_two_pkg::RUN_POS],
                           run_reg, guard_open_o);
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      amp_transconductance_us_o <= boost_reg_two_pkg::GM_BASE_US;
      shunt_current_limit_mv_o  <= boost_reg_two_pkg::LIMIT_MV_0;
      vout_10mv_o               <= boost_reg_two_pkg::VOUT_BASE_10MV;
      op_mode_o                 <= boost_reg_two_pkg::MODE_LIMP;
    end else begin
      amp_transconductance_us_o <= boost_reg_two_pkg::GM_BASE_US
                                 + 10'(boost_reg_two_pkg::GM_STEP_US * {8'h00, gm_reg});
      case (limit_reg)
        2'h0:    shunt_current_limit_mv_o <= boost_reg_two_pkg::LIMIT_MV_0;
        2'h1:    shunt_current_limit_mv_o <= boost_reg_two_pkg::LIMIT_MV_1;
        2'h2:    shunt_current_limit_mv_o <= boost_reg_two_pkg::LIMIT_MV_2;
        default: shunt_current_limit_mv_o <= boost_reg_two_pkg::LIMIT_MV_3;
      endcase
      vout_10mv_o <= boost_reg_two_pkg::VOUT_BASE_10MV
                   + 13'(boost_reg_two_pkg::VOUT_STEP_10MV * {6'h00, output_voltage_code_o});
      op_mode_o <= mode_of(sleep_reg, run_reg);
    end
  end

  // ----------------------------------------------------------------
  // Sync pin and clock selection
  // ----------------------------------------------------------------
  // Master drives an inverted boost clock; slave runs from the pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_pin_o    <= 1'b0;
      sync_pin_oe_o <= 1'b0;
      boost_clk_o   <= 1'b0;
    end else begin
      sync_pin_o    <= ~boost_clk_i;
      sync_pin_oe_o <= ~role_reg;
      boost_clk_o   <= role_reg ? sync_pin_i : boost_clk_i;
    end
  end

  // ----------------------------------------------------------------
  // Read back and error flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_o   <= 1'b0;
      rd_data_o    <= 24'h000000;
      parity_err_o <= 1'b0;
    end else begin
      rd_valid_o   <= good_frame & (frame_i.addr == boost_reg_two_pkg::MODE_REG_ADDR);
      parity_err_o <= frame_valid_i & ~parity_ok & ~otp_pending_reg;
      if (good_frame & (frame_i.addr == boost_reg_two_pkg::MODE_REG_ADDR)) begin
        rd_data_o <= rd_image;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_shutoff_locked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_mode && !guard_open_o && !amp_shutoff_bit_o |=> !amp_shutoff_bit_o)
    else $error("shutoff set while guard closed");
  a_sleep_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_mode && !frame_i.data[3] |=> !sleep_reg)
    else $error("sleep clear refused");
  a_run_guarded: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_mode && guard_open_o && !wake_i && frame_i.data[2] |=> run_reg)
    else $error("run set refused with guard open");
  a_guard_closes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    good_frame && !unlock_frame |=> !guard_open_o)
    else $error("guard stayed open");
  a_parity_reject: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    frame_valid_i && !(^frame_i.data) && !otp_pending_reg |=> parity_err_o && $stable(output_voltage_code_o))
    else $error("bad parity frame accepted");
  a_read_image: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_valid_o |-> (^rd_data_o) && !rd_data_o[16] && !rd_data_o[4])
    else $error("read image parity or unused bits wrong");
  a_vout_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $stable(output_voltage_code_o) |=> vout_10mv_o == 13'h05be + 13'h0033 * {6'h00, $past(output_voltage_code_o)})
    else $error("voltage decode wrong");
  a_gm_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    gm_reg == 2'h3 ##1 gm_reg == 2'h3 |-> amp_transconductance_us_o == 10'h320)
    else $error("transconductance decode wrong");
  a_standby_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sleep_reg && !run_reg |=> op_mode_o == boost_reg_two_pkg::MODE_STANDBY)
    else $error("standby not entered");
  a_sync_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !role_reg |=> sync_pin_oe_o && (sync_pin_o == !$past(boost_clk_i)))
    else $error("master not driving sync pin");

endmodule : boost_regulation_and_mode_control

`default_nettype wire

// *** test/frame_master.sv ***
// Purpose: Frame source standing in for the serial bus master.
// Assumes: Frames reach the block already decoded, each held valid for one clock.
// Notes:   Odd parity is filled in here unless a bad frame is asked for.
`timescale 1ns/100ps
`default_nettype none

module frame_master (
  // Clock
  input  wire logic                      clk_i,
  // Frame port
  output var  logic                      frame_valid_o,
  output var  boost_reg_two_pkg::frame_t frame_o
);
  // ----------------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------------
  initial begin
    frame_valid_o = 1'b0;
    frame_o       = '0;
  end

  // Sends one frame, held until the taking edge, then released
  task automatic send(input logic wr_i, input logic [5:0] addr_i, input logic [23:0] data_i,
                      input logic bad_i);
    logic [23:0] d;
    d    = data_i;
    d[0] = ~(^data_i[23:1]) ^ bad_i;
    @(posedge clk_i);
    #1;
    frame_valid_o = 1'b1;
    frame_o       = {wr_i, addr_i, d};
    @(posedge clk_i);
    #1;
    frame_valid_o = 1'b0;
    frame_o       = ~frame_o;  // No stale frame left on the port
  endtask : send
endmodule : frame_master
`default_nettype wire

// *** test/boost_control_register_two_test.sv ***
// Purpose: Self-checking bench for the regulation and mode control register.
// Assumes: Frame master model drives the frame port.
// Notes:   Expected images are built here from the bit map.
`timescale 1ns/100ps
`default_nettype none

module boost_control_register_two_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                                clk = 1'b0;
  logic                                rst_n = 1'b0;
  logic                                frame_valid;
  boost_reg_two_pkg::frame_t           frame;
  logic                                wake = 1'b0;
  boost_reg_two_pkg::otp_defaults_t    otp = {6'h2a, 1'b0, 2'h2, 2'h1, 7'h55, 1'b1};
  logic                                boost_clk = 1'b1;
  logic                                sync_pin = 1'b0;
  logic                                rd_valid, parity_err, guard_open, shutoff, sync_o, sync_oe;
  logic                                boost_clk_o;
  logic [23:0]                         rd_data;
  logic [5:0]                          slope;
  logic [9:0]                          gm_us;
  logic [7:0]                          lim_mv;
  logic [6:0]                          vcode;
  logic [12:0]                         v10mv;
  boost_reg_two_pkg::op_mode_t         mode;
  int                                  err_total = 0;
  int                                  n_tests = 0;
  logic [7:0]                          lim_tab [4] = '{8'h32, 8'h55, 8'h73, 8'h96};
  logic [6:0]                          v_tab [4] = '{7'h00, 7'h01, 7'h40, 7'h7f};

  always #50 clk = ~clk;

  frame_master fm (.clk_i(clk), .frame_valid_o(frame_valid), .frame_o(frame));

  boost_regulation_and_mode_control DUT (
    .clk_i(clk), .rst_n_i(rst_n), .frame_valid_i(frame_valid), .frame_i(frame), .wake_i(wake),
    .otp_i(otp), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .parity_err_o(parity_err),
    .guard_open_o(guard_open), .slope_comp_setting_o(slope), .amp_shutoff_bit_o(shutoff),
    .amp_transconductance_us_o(gm_us), .shunt_current_limit_mv_o(lim_mv),
    .output_voltage_code_o(vcode), .vout_10mv_o(v10mv), .op_mode_o(mode),
    .boost_clk_i(boost_clk), .sync_pin_i(sync_pin), .sync_pin_o(sync_o),
    .sync_pin_oe_o(sync_oe), .boost_clk_o(boost_clk_o));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register image with zero unused bits and odd parity in bit 0
  function automatic logic [23:0] img(input logic [5:0] s, input logic d, input logic [1:0] g,
                                      input logic [1:0] l, input logic [6:0] v, input logic [2:0] m);
    logic [23:0] w;
    w    = {s, d, 1'b0, g, l, v, 1'b0, m, 1'b0};
    w[0] = ~(^w[23:1]);
    return w;
  endfunction : img

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [23:0] w);
    fm.send(1'b1, boost_reg_two_pkg::MODE_REG_ADDR, w, 1'b0);
  endtask : wr

  // Read frame: the answer carries the image held before the frame
  task automatic rd(input logic [23:0] exp);
    fm.send(1'b0, boost_reg_two_pkg::MODE_REG_ADDR, 24'h000000, 1'b0);
    chk({23'h0, rd_valid}, 24'h1);
    chk(rd_data, exp);
  endtask : rd

  task automatic release_guard(input logic bad);
    fm.send(1'b1, boost_reg_two_pkg::GUARD_REG_ADDR, 24'h000002, bad);
  endtask : release_guard

  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #(2000 * 100);
    err_total++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    rd(img(6'h2a, 1'b0, 2'h2, 2'h1, 7'h55, 3'b001));
    chk({14'h0, gm_us}, 24'd600);
    chk({11'h0, v10mv}, 24'd5805);
    chk({10'h0, slope, shutoff, vcode}, {10'h0, 6'h2a, 1'b0, 7'h55});
    // Guarded bits refused while closed, unused bits dropped
    wr(img(6'h15, 1'b1, 2'h3, 2'h0, 7'h00, 3'b110) | 24'h010010);
    rd(img(6'h15, 1'b0, 2'h3, 2'h0, 7'h00, 3'b000));
    chk({22'h0, sync_oe, sync_o}, 24'h2);
    // Master follows the boost clock, not the sync pin
    boost_clk = 1'b0;
    sync_pin  = 1'b1;
    settle();
    chk({21'h0, sync_oe, sync_o, boost_clk_o}, 24'h6);
    for (int i = 0; i < 4; i++) begin
      wr(img(6'h00, 1'b0, i[1:0], i[1:0], v_tab[i], 3'b000));
      settle();
      chk({14'h0, gm_us}, 24'(200 + 200 * i));
      chk({16'h0, lim_mv}, {16'h0, lim_tab[i]});
      chk({11'h0, v10mv}, 24'(1470 + 51 * int'(v_tab[i])));
    end
    // Standby entry, then unguarded clear
    release_guard(1'b0);
    chk({23'h0, guard_open}, 24'h1);
    wr(img(6'h00, 1'b0, 2'h0, 2'h0, 7'h00, 3'b100));
    chk({23'h0, guard_open}, 24'h0);
    settle();
    chk({22'h0, mode}, {22'h0, boost_reg_two_pkg::MODE_STANDBY});
    wr(img(6'h00, 1'b0, 2'h0, 2'h0, 7'h00, 3'b000));
    settle();
    chk({22'h0, mode}, {22'h0, boost_reg_two_pkg::MODE_LIMP});
    // Active entry, then wake-up drops to limp
    release_guard(1'b0);
    wr(img(6'h00, 1'b0, 2'h0, 2'h0, 7'h00, 3'b010));
    settle();
    chk({22'h0, mode}, {22'h0, boost_reg_two_pkg::MODE_ACTIVE});
    wake = 1'b1;
    settle();
    wake = 1'b0;
    settle();
    chk({22'h0, mode}, {22'h0, boost_reg_two_pkg::MODE_LIMP});
    // Sleep and run both set: run wins
    release_guard(1'b0);
    wr(img(6'h00, 1'b0, 2'h0, 2'h0, 7'h00, 3'b110));
    settle();
    chk({22'h0, mode}, {22'h0, boost_reg_two_pkg::MODE_ACTIVE});
    // Any other good frame closes the guard
    release_guard(1'b0);
    fm.send(1'b0, 6'h03, 24'h000000, 1'b0);
    wr(img(6'h00, 1'b1, 2'h0, 2'h0, 7'h00, 3'b000));
    rd(img(6'h00, 1'b0, 2'h0, 2'h0, 7'h00, 3'b000));
    // Bad parity frame refused and does not close the guard
    release_guard(1'b1);
    chk({22'h0, parity_err, guard_open}, 24'h2);
    release_guard(1'b0);
    fm.send(1'b1, boost_reg_two_pkg::MODE_REG_ADDR, 24'h020000, 1'b1);
    chk({22'h0, parity_err, guard_open}, 24'h3);
    wr(img(6'h00, 1'b1, 2'h0, 2'h0, 7'h00, 3'b000));
    rd(img(6'h00, 1'b1, 2'h0, 2'h0, 7'h00, 3'b000));
    wr(img(6'h00, 1'b0, 2'h0, 2'h0, 7'h00, 3'b001));
    rd(img(6'h00, 1'b0, 2'h0, 2'h0, 7'h00, 3'b001));
    chk({22'h0, sync_oe, boost_clk_o}, 24'h1);
    wrap_up();
  end
endmodule : boost_control_register_two_test
`default_nettype wire
